// ---- ssem_assertions.sv ----
`timescale 1ns/1ps
module ssem_checker
  import ssem_pkg::*;
(
  // Clock and reset
  input  wire logic            SYS_CLK_IN,
  input  wire logic            RST_IN,
  // Watched inputs
  input  wire logic            GLOBAL_EVENT_MASK_IN,
  input  wire logic            START_IN,
  input  wire ssem_events_type EVENTS_IN,
  input  wire logic [7:0]      INPUT_LEVEL_IN,
  // Watched outputs
  input  wire ssem_events_type EVENTS_OUT,
  input  wire logic [7:0]      INPUT_SET_BMC_OUT,
  input  wire logic [7:0]      INPUT_SET_HOST_OUT,
  input  wire logic [7:0]      INPUT_LEVEL_OUT,
  input  wire logic [1:0]      SLEEP_STATE_OUT,
  input  wire ssem_events_type EFFECTIVE_MASK_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  gate_events_a: assert property (EVENTS_OUT == ($past(EVENTS_IN) & ~EFFECTIVE_MASK_OUT))
    else $error("gated events differ from events under the mask");
  global_mask_a: assert property (($past(GLOBAL_EVENT_MASK_IN) || !$past(START_IN))
    |-> EFFECTIVE_MASK_OUT == '1)
    else $error("global masking not complete");
  global_quiet_a: assert property (($past(GLOBAL_EVENT_MASK_IN) || !$past(START_IN))
    |-> EVENTS_OUT == '0)
    else $error("event passed while globally masked");
  set_copies_a: assert property (INPUT_SET_BMC_OUT == EVENTS_OUT.inputs
    && INPUT_SET_HOST_OUT == EVENTS_OUT.inputs)
    else $error("status set outputs differ from gated inputs");
  level_pass_a: assert property (!$past(RST_IN) |-> INPUT_LEVEL_OUT == $past(INPUT_LEVEL_IN))
    else $error("live input level altered");
  s0_clear_a: assert property ((SLEEP_STATE_OUT == SLEEP_S0
    && !$past(GLOBAL_EVENT_MASK_IN) && $past(START_IN)) |-> EFFECTIVE_MASK_OUT[10:0] == 11'h000)
    else $error("sleep mask applied in the awake state");
  s45_tach_a: assert property ((!$past(RST_IN) && SLEEP_STATE_OUT == SLEEP_S45
    && !$past(GLOBAL_EVENT_MASK_IN) && $past(START_IN)) |-> EFFECTIVE_MASK_OUT.tach == 4'h0)
    else $error("tach masked in the deepest state");
  zone_pair_a: assert property (EFFECTIVE_MASK_OUT.zone_temp == EFFECTIVE_MASK_OUT.zone_diode
    && !(^EFFECTIVE_MASK_OUT.zone_temp))
    else $error("zone masks not applied together");
  reset_s45_a: assert property ($past(RST_IN) |-> SLEEP_STATE_OUT == SLEEP_S45)
    else $error("sleep field not deepest after reset");
endmodule : ssem_checker

// ---- ssem_mask_reg.sv ----
`timescale 1ns/1ps
module ssem_mask_reg
  import ssem_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hff
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Write port
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // Stored value
  output logic      [7:0] value_out
);

  logic [7:0] value_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      value_q <= RESET_VALUE;
    end else if (wr_in) begin
      value_q <= wdata_in & WRITE_MASK;
    end
  end

  assign value_out = value_q;

endmodule : ssem_mask_reg

// ---- ssem_pkg.sv ----
package ssem_pkg;

  // Register file layout: one byte per register, contiguous from the sleep state control.
  localparam int unsigned NUM_REGS = 9;
  localparam logic [7:0] SLEEP_CTRL_OFFSET         = 8'he4;
  localparam logic [7:0] SLEEP1_INPUT_MASK_OFFSET  = 8'he5;
  localparam logic [7:0] SLEEP1_TACH_MASK_OFFSET   = 8'he6;
  localparam logic [7:0] SLEEP3_INPUT_MASK_OFFSET  = 8'he7;
  localparam logic [7:0] SLEEP3_TACH_MASK_OFFSET   = 8'he8;
  localparam logic [7:0] SLEEP3_VOLT_TEMP_OFFSET   = 8'he9;
  localparam logic [7:0] SLEEP45_INPUT_MASK_OFFSET = 8'hea;
  localparam logic [7:0] SLEEP45_VOLT_TEMP_OFFSET  = 8'heb;
  localparam logic [7:0] INPUT_ERROR_MASK_OFFSET   = 8'hec;

  // Indices into the register array, equal to offset minus the first offset.
  localparam int unsigned IDX_SLEEP_CTRL   = 0;
  localparam int unsigned IDX_S1_INPUT     = 1;
  localparam int unsigned IDX_S1_TACH      = 2;
  localparam int unsigned IDX_S3_INPUT     = 3;
  localparam int unsigned IDX_S3_TACH      = 4;
  localparam int unsigned IDX_S3_VOLT_TEMP = 5;
  localparam int unsigned IDX_S45_INPUT    = 6;
  localparam int unsigned IDX_S45_VOLT     = 7;
  localparam int unsigned IDX_INPUT_ERROR  = 8;

  // Reset values, highest index first.
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET_VALUES = {
    8'hff, 8'h07, 8'hff, 8'h07, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h03
  };

  // Writable bits; reserved bits are held at zero and read as zero.
  localparam logic [NUM_REGS-1:0][7:0] REG_WRITE_MASKS = {
    8'hff, 8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h03
  };

  // Field positions.
  localparam int unsigned SLEEP_FIELD_LSB  = 0;
  localparam int unsigned TACH_FIELD_LSB   = 0;
  localparam int unsigned ANALOG_FIELD_LSB = 0;
  localparam int unsigned ZONE_TEMP_BIT    = 3;

  typedef enum logic [1:0] {
    SLEEP_S0  = 2'h0,
    SLEEP_S1  = 2'h1,
    SLEEP_S3  = 2'h2,
    SLEEP_S45 = 2'h3
  } ssem_sleep_type;

  // One bit per error source; used for raw events, masked events and masks.
  typedef struct packed {
    logic [7:0] inputs;
    logic [3:0] tach;
    logic [2:0] analog;
    logic [1:0] zone_temp;
    logic [1:0] zone_diode;
  } ssem_events_type;

  localparam ssem_events_type NO_EVENTS = '0;

endpackage : ssem_pkg

// ---- ssem_sleep_select.sv ----
`timescale 1ns/1ps
module ssem_sleep_select
  import ssem_pkg::*;
(
  // Sleep state and register contents
  input  wire ssem_sleep_type               state_in,
  input  wire logic [NUM_REGS-1:0][7:0]     regs_in,
  // Mask that the current sleep state applies
  output ssem_events_type                   mask_out
);

  always_comb begin
    mask_out = NO_EVENTS;
    case (state_in)
      SLEEP_S0: begin
        mask_out = NO_EVENTS;
      end
      SLEEP_S1: begin
        mask_out.inputs = regs_in[IDX_S1_INPUT];
        mask_out.tach   = regs_in[IDX_S1_TACH][TACH_FIELD_LSB +: 4];
      end
      SLEEP_S3: begin
        mask_out.inputs     = regs_in[IDX_S3_INPUT];
        mask_out.tach       = regs_in[IDX_S3_TACH][TACH_FIELD_LSB +: 4];
        mask_out.analog     = regs_in[IDX_S3_VOLT_TEMP][ANALOG_FIELD_LSB +: 3];
        mask_out.zone_temp  = {2{regs_in[IDX_S3_VOLT_TEMP][ZONE_TEMP_BIT]}};
        mask_out.zone_diode = {2{regs_in[IDX_S3_VOLT_TEMP][ZONE_TEMP_BIT]}};
      end
      SLEEP_S45: begin
        mask_out.inputs     = regs_in[IDX_S45_INPUT];
        mask_out.analog     = regs_in[IDX_S45_VOLT][ANALOG_FIELD_LSB +: 3];
        mask_out.zone_temp  = {2{regs_in[IDX_S45_VOLT][ZONE_TEMP_BIT]}};
        mask_out.zone_diode = {2{regs_in[IDX_S45_VOLT][ZONE_TEMP_BIT]}};
      end
      default: begin
        mask_out = NO_EVENTS;
      end
    endcase
  end

endmodule : ssem_sleep_select

// ---- ssem_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - In S1, set bits of the S1 input mask suppress input 0-7 errors; reset FFh.
// - In S1, Sleep1_tach_mask bits 0-3 suppress tach 1-4 errors; upper reserved; reset 0Fh.
// - In S3, set bits of the S3 input mask suppress input 0-7 errors; reset FFh.
// - In S3, Sleep3_tach_mask bits 0-3 suppress tach 1-4 errors; upper reserved; reset 0Fh.
// - In S3, volt mask bits 0-2 suppress analog inputs 12-14; reset 07h.
// - In S3, volt mask bit 3 suppresses zone 1/2 temperature and diode faults.
// - In S4/5, set bits of the S4/5 input mask suppress input errors; reset FFh.
// - In S4/5, volt mask bits 0-2 suppress analog 12-14; upper reserved; reset 07h.
// - In S4/5, volt mask bit 3 suppresses zone 1/2 temperature and diode faults.
// - The input error mask suppresses input errors in every sleep state; reset FFh.
// - A set input error mask bit blocks both BMC and host input status setting.
// - The input error mask never affects the live input level report.
// - Two-bit sleep field: 00 S0 no sleep masking, 01 S1, 10 S3, 11 S4/5.
// - Reset forces the sleep field to the S4/5 code.
// - Global mask set or start clear masks every error event.
module ssem_top
  import ssem_pkg::*;
(
  // Clock and reset
  input  wire logic            SYS_CLK_IN,
  input  wire logic            RST_IN,
  // Register port
  input  wire logic [7:0]      REG_ADDR_IN,
  input  wire logic [7:0]      REG_WDATA_IN,
  input  wire logic            REG_WR_IN,
  input  wire logic            REG_RD_IN,
  output logic      [7:0]      REG_RDATA_OUT,
  output logic                 REG_RVALID_OUT,
  output logic                 REG_UNMAPPED_OUT,
  // Configuration bits held elsewhere
  input  wire logic            GLOBAL_EVENT_MASK_IN,
  input  wire logic            START_IN,
  // Raw error events and live input levels
  input  wire ssem_events_type EVENTS_IN,
  input  wire logic [7:0]      INPUT_LEVEL_IN,
  // Gated events and retimed live input levels
  output ssem_events_type      EVENTS_OUT,
  output logic      [7:0]      INPUT_SET_BMC_OUT,
  output logic      [7:0]      INPUT_SET_HOST_OUT,
  output logic      [7:0]      INPUT_LEVEL_OUT,
  // State visibility
  output logic      [1:0]      SLEEP_STATE_OUT,
  output ssem_events_type      EFFECTIVE_MASK_OUT
);

  logic [NUM_REGS-1:0][7:0] regs;
  logic [NUM_REGS-1:0]      reg_wr;
  logic                     addr_hit;
  logic [3:0]               addr_idx;
  ssem_sleep_type           sleep_state;
  ssem_events_type          sleep_mask;
  ssem_events_type          general_mask;
  ssem_events_type          effective_mask_d;
  ssem_events_type          effective_mask_q;
  ssem_events_type          events_d;
  ssem_events_type          events_q;
  logic [7:0]               input_set_q;
  logic [7:0]               input_level_q;
  logic [7:0]               rdata_q;
  logic                     rvalid_q;
  logic                     unmapped_q;
  logic [1:0]               sleep_state_q;

  // Address decode: one branch per mapped offset, so the map does not rely on the offsets staying contiguous.
  always_comb begin
    addr_hit = 1'b1;
    addr_idx = 4'h0;
    if (REG_ADDR_IN == SLEEP_CTRL_OFFSET) begin
      addr_idx = 4'(IDX_SLEEP_CTRL);
    end else if (REG_ADDR_IN == SLEEP1_INPUT_MASK_OFFSET) begin
      addr_idx = 4'(IDX_S1_INPUT);
    end else if (REG_ADDR_IN == SLEEP1_TACH_MASK_OFFSET) begin
      addr_idx = 4'(IDX_S1_TACH);
    end else if (REG_ADDR_IN == SLEEP3_INPUT_MASK_OFFSET) begin
      addr_idx = 4'(IDX_S3_INPUT);
    end else if (REG_ADDR_IN == SLEEP3_TACH_MASK_OFFSET) begin
      addr_idx = 4'(IDX_S3_TACH);
    end else if (REG_ADDR_IN == SLEEP3_VOLT_TEMP_OFFSET) begin
      addr_idx = 4'(IDX_S3_VOLT_TEMP);
    end else if (REG_ADDR_IN == SLEEP45_INPUT_MASK_OFFSET) begin
      addr_idx = 4'(IDX_S45_INPUT);
    end else if (REG_ADDR_IN == SLEEP45_VOLT_TEMP_OFFSET) begin
      addr_idx = 4'(IDX_S45_VOLT);
    end else if (REG_ADDR_IN == INPUT_ERROR_MASK_OFFSET) begin
      addr_idx = 4'(IDX_INPUT_ERROR);
    end else begin
      addr_hit = 1'b0;
    end
  end

  // One storage register per address; reserved bits are dropped on write.
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      assign reg_wr[i] = REG_WR_IN && addr_hit && (addr_idx == 4'(i));

      ssem_mask_reg #(
        .RESET_VALUE (REG_RESET_VALUES[i]),
        .WRITE_MASK  (REG_WRITE_MASKS[i])
      ) u_reg (
        .clk_in    (SYS_CLK_IN),
        .rst_in    (RST_IN),
        .wr_in     (reg_wr[i]),
        .wdata_in  (REG_WDATA_IN),
        .value_out (regs[i])
      );
    end
  endgenerate

  assign sleep_state = ssem_sleep_type'(regs[IDX_SLEEP_CTRL][SLEEP_FIELD_LSB +: 2]);

  ssem_sleep_select u_sleep_select (
    .state_in (sleep_state),
    .regs_in  (regs),
    .mask_out (sleep_mask)
  );

  // The general input mask applies whatever the sleep state is.
  always_comb begin
    general_mask        = NO_EVENTS;
    general_mask.inputs = regs[IDX_INPUT_ERROR];
  end

  // Global masking overrides every per-source setting without altering the stored masks.
  always_comb begin
    if (GLOBAL_EVENT_MASK_IN || !START_IN) begin
      effective_mask_d = ~NO_EVENTS;
    end else begin
      effective_mask_d = general_mask | sleep_mask;
    end
    events_d = EVENTS_IN & ~effective_mask_d;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      events_q         <= NO_EVENTS;
      effective_mask_q <= ~NO_EVENTS;
    end else begin
      events_q         <= events_d;
      effective_mask_q <= effective_mask_d;
    end
  end

  // Both status banks see the same gated input events.
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      input_set_q <= 8'h00;
    end else begin
      input_set_q <= events_d.inputs;
    end
  end

  // Live levels bypass every mask; they are only retimed.
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      input_level_q <= 8'h00;
    end else begin
      input_level_q <= INPUT_LEVEL_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sleep_state_q <= REG_RESET_VALUES[IDX_SLEEP_CTRL][1:0];
    end else begin
      sleep_state_q <= regs[IDX_SLEEP_CTRL][SLEEP_FIELD_LSB +: 2];
    end
  end

  // Read path: data is registered, so a read that follows a write sees the new value.
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD_IN;
      if (REG_RD_IN && addr_hit) begin
        rdata_q <= regs[addr_idx];
      end else if (REG_RD_IN) begin
        rdata_q <= 8'h00;
      end
    end
  end

  // Unmapped writes are ignored and unmapped reads return 00h; both raise this one-cycle flag.
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      unmapped_q <= 1'b0;
    end else begin
      unmapped_q <= (REG_RD_IN || REG_WR_IN) && !addr_hit;
    end
  end

  assign REG_RDATA_OUT      = rdata_q;
  assign REG_RVALID_OUT     = rvalid_q;
  assign REG_UNMAPPED_OUT   = unmapped_q;
  assign EVENTS_OUT         = events_q;
  assign INPUT_SET_BMC_OUT  = input_set_q;
  assign INPUT_SET_HOST_OUT = input_set_q;
  assign INPUT_LEVEL_OUT    = input_level_q;
  assign SLEEP_STATE_OUT    = sleep_state_q;
  assign EFFECTIVE_MASK_OUT = effective_mask_q;

endmodule : ssem_top

// ---- ssem_top_tb.sv ----
`timescale 1ns/1ps
module ssem_top_tb;
  import ssem_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, global_event_mask = 1'b0, start = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lvl = 8'h00;
  ssem_events_type ev_in = NO_EVENTS;
  logic [7:0] rdata, set_bmc, set_host, lvl_out;
  logic rvalid, unmapped;
  logic [1:0] state;
  ssem_events_type ev_out, eff_mask;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  logic [7:0] rst_vals [9] = '{8'h03, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h07, 8'hff, 8'h07, 8'hff};
  logic [7:0] ful_vals [9] = '{8'h03, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h0f, 8'hff};
  always #50 clk = ~clk;
  ssem_top dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .REG_UNMAPPED_OUT(unmapped),
    .GLOBAL_EVENT_MASK_IN(global_event_mask), .START_IN(start), .EVENTS_IN(ev_in), .INPUT_LEVEL_IN(lvl),
    .EVENTS_OUT(ev_out), .INPUT_SET_BMC_OUT(set_bmc), .INPUT_SET_HOST_OUT(set_host),
    .INPUT_LEVEL_OUT(lvl_out), .SLEEP_STATE_OUT(state), .EFFECTIVE_MASK_OUT(eff_mask));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_ev(input ssem_events_type got, input ssem_events_type exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t events got %h expected %h", $time, got, exp);
    end
  endtask : cmp_ev
  // Each access leaves an idle cycle so a strobe never rises in the step that lowered it.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
    @(posedge clk) #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic u);
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    rd = 1'b0;
    cmp_byte(rdata, exp);
    cmp_byte({6'h00, rvalid, unmapped}, {6'h00, 1'b1, u});
    @(posedge clk) #1;
  endtask : reg_rd
  // Two patterns so that a mask bit stuck at either level shows.
  task automatic ev_step(input ssem_events_type m);
    ssem_events_type p;
    for (int i = 0; i < 2; i++) begin
      p = i ? 19'h5a5a5 : 19'h7ffff;
      ev_in = p;
      lvl = p.inputs;
      @(posedge clk) #1;
      cmp_ev(ev_out, p & ~m);
      cmp_ev(eff_mask, m);
      cmp_byte(set_bmc, p.inputs & ~m.inputs);
      cmp_byte(set_host, p.inputs & ~m.inputs);
      cmp_byte(lvl_out, p.inputs);
    end
  endtask : ev_step
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    cmp_byte({6'h00, state}, 8'h03);
    for (int i = 0; i < 9; i++) reg_rd(8'he4 + 8'(i), rst_vals[i], 1'b0);
    ev_step(19'h7ffff);
    start = 1'b1;
    ev_step({8'hff, 4'h0, 3'h7, 4'h0});
    reg_wr(8'hec, 8'h00);
    reg_wr(8'hea, 8'h5a);
    reg_wr(8'heb, 8'h08);
    ev_step({8'h5a, 4'h0, 3'h0, 4'hf});
    reg_wr(8'he4, 8'h02);
    cmp_byte({6'h00, state}, 8'h02);
    reg_wr(8'he7, 8'h0f);
    reg_wr(8'he8, 8'h05);
    reg_wr(8'he9, 8'h0a);
    ev_step({8'h0f, 4'h5, 3'h2, 4'hf});
    reg_wr(8'he4, 8'h01);
    reg_wr(8'he5, 8'h3c);
    reg_wr(8'he6, 8'h09);
    ev_step({8'h3c, 4'h9, 3'h0, 4'h0});
    reg_wr(8'he4, 8'h00);
    reg_wr(8'hec, 8'h81);
    ev_step({8'h81, 11'h000});
    global_event_mask = 1'b1;
    ev_step(19'h7ffff);
    global_event_mask = 1'b0;
    for (int i = 0; i < 9; i++) reg_wr(8'he4 + 8'(i), 8'hff);
    for (int i = 0; i < 9; i++) reg_rd(8'he4 + 8'(i), ful_vals[i], 1'b0);
    reg_wr(8'hed, 8'h55);
    reg_rd(8'hed, 8'h00, 1'b1);
    reg_wr(8'he4, 8'h00);
    rst = 1'b1;
    @(posedge clk) #1;
    rst = 1'b0;
    cmp_byte({6'h00, state}, 8'h03);
    reg_rd(8'he4, 8'h03, 1'b0);
    ev_step({8'hff, 4'h0, 3'h7, 4'h0});
    complete_run();
  end
endmodule : ssem_top_tb
bind ssem_top ssem_checker chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .GLOBAL_EVENT_MASK_IN(GLOBAL_EVENT_MASK_IN),
  .START_IN(START_IN), .EVENTS_IN(EVENTS_IN), .INPUT_LEVEL_IN(INPUT_LEVEL_IN), .EVENTS_OUT(EVENTS_OUT),
  .INPUT_SET_BMC_OUT(INPUT_SET_BMC_OUT), .INPUT_SET_HOST_OUT(INPUT_SET_HOST_OUT), .INPUT_LEVEL_OUT(INPUT_LEVEL_OUT),
  .SLEEP_STATE_OUT(SLEEP_STATE_OUT), .EFFECTIVE_MASK_OUT(EFFECTIVE_MASK_OUT));
